// file: inc/rectifier_pkg.sv
// shared constants and types for the rectifier address and control block
package rectifier_pkg;
  // clock and documented times
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned SOFT_DELAY_S = 10;
  localparam int unsigned RAMP_MS = 120;
  localparam int unsigned AUX_LEAD_MS = 450;
  localparam int unsigned PG_WARN_MS = 3;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned SOFT_DELAY_CYC = SOFT_DELAY_S * CLK_HZ;
  localparam int unsigned RAMP_CYC = RAMP_MS * CYC_PER_MS;
  localparam int unsigned AUX_LEAD_CYC = AUX_LEAD_MS * CYC_PER_MS;
  localparam int unsigned PG_WARN_CYC = PG_WARN_MS * CYC_PER_MS;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;
  localparam int CNT_W = 28;

  // sensed levels: position and vprog pins in 10 mV steps, input in volts
  localparam int LEVEL_W = 9;
  localparam int POS_W = 4;
  localparam int VOUT_W = 13;
  localparam int UNIT_EDGES = 10;
  localparam int RACK_EDGES = 7;
  // midpoints between neighbouring tabulated levels, highest first
  localparam logic [8:0] UNIT_EDGE [UNIT_EDGES] = '{9'h13b, 9'h11c, 9'h0fb,
    9'h0da, 9'h0b9, 9'h098, 9'h077, 9'h056, 9'h035, 9'h012};
  localparam logic [8:0] RACK_EDGE [RACK_EDGES] = '{9'h131, 9'h0ff, 9'h0cd,
    9'h0a0, 9'h078, 9'h04b, 9'h019};

  // address byte layout
  localparam logic [2:0] ADDR_FIXED = 3'h4;
  localparam logic [6:0] BCAST_ADDR = 7'h00;
  localparam logic DIR_READ = 1'h1;

  // output voltage setpoint, 10 mV units
  localparam logic [8:0] VPROG_DEFAULT_MIN = 9'h12c;
  localparam logic [12:0] VOUT_DEFAULT = 13'h1518;
  localparam logic [12:0] VOUT_PIN_BASE = 13'h1130;
  localparam logic [6:0] VPROG_GAIN = 7'h4b;
  localparam int VPROG_SHIFT = 4;

  // input indicator threshold in volts
  localparam logic [8:0] VIN_LED_MIN = 9'h050;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_DELAY,
    ST_RAMP,
    ST_ON,
    ST_WARN
  } run_state_t;
endpackage : rectifier_pkg

// file: logic/position_decoder.sv
// position pin quantizer and address bit lookup
`timescale 1ns/100ps
module position_decoder (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // sensed pin levels
  input wire logic [rectifier_pkg::LEVEL_W-1:0] unit_level_in,
  input wire logic [rectifier_pkg::LEVEL_W-1:0] rack_level_in,
  // decoded address bits
  output logic [rectifier_pkg::POS_W-1:0] addr_bits_out,
  output logic addr_valid_out
);
  import rectifier_pkg::*;

  // unit position 1..10, 0 when the pin sits at the open level
  function automatic logic [3:0] unit_pos(input logic [8:0] lvl);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < UNIT_EDGES; i++) begin
      if (lvl < UNIT_EDGE[i]) n = n + 4'h1;
    end
    return n;
  endfunction : unit_pos

  // rack position 1..8, open pin reads as rack 1
  function automatic logic [3:0] rack_pos(input logic [8:0] lvl);
    logic [3:0] n;
    n = 4'h1;
    for (int i = 0; i < RACK_EDGES; i++) begin
      if (lvl < RACK_EDGE[i]) n = n + 4'h1;
    end
    return n;
  endfunction : rack_pos

  // fixed unit by rack lookup, four layouts; bit 4 flags a legal pair
  function automatic logic [4:0] lookup(input logic [3:0] u,
                                        input logic [3:0] r);
    logic [4:0] res;
    res = 5'h00;
    if (u >= 4'h1 && u <= 4'h4 && r >= 4'h1 && r <= 4'h4) begin
      res = {1'h1, 4'((r - 4'h1) * 4'h4 + (u - 4'h1))};
    end else if (u >= 4'h1 && u <= 4'h5 && r >= 4'h6) begin
      res = {1'h1, 4'((r - 4'h6) * 4'h5 + (u - 4'h1))};
    end else if ((u == 4'h6 || u == 4'h7) && r >= 4'h1) begin
      res = {1'h1, 4'((r - 4'h1) * 4'h2 + (u - 4'h6))};
    end else if (u >= 4'h8 && u <= 4'ha && r >= 4'h4) begin
      res = {1'h1, 4'((r - 4'h4) * 4'h3 + (u - 4'h8))};
    end
    return res;
  endfunction : lookup

  // nearest-level quantizing, then the table
  wire logic [3:0] unit_now = unit_pos(unit_level_in);
  wire logic [3:0] rack_now = rack_pos(rack_level_in);
  wire logic [4:0] entry = lookup(unit_now, rack_now);

  // registered so the address never glitches between table rows
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      addr_bits_out <= 4'h0;
      addr_valid_out <= 1'h0;
    end else begin
      addr_bits_out <= entry[3:0];
      addr_valid_out <= entry[4];
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  property p_unit_open_invalid;
    unit_level_in >= UNIT_EDGE[0] |=> !addr_valid_out;
  endproperty
  a_unit_open_invalid: assert property (p_unit_open_invalid)
    else $error("open unit pin gave a valid address");

  // sampled reset in the antecedent: no attempt starts on the release edge
  property p_corner_address;
    rstn_in && unit_level_in < UNIT_EDGE[9] && rack_level_in < RACK_EDGE[6]
      |=> addr_valid_out && addr_bits_out == 4'he;
  endproperty
  a_corner_address: assert property (p_corner_address)
    else $error("unit 10 rack 8 did not map to 1110");
endmodule : position_decoder

// file: logic/rectifier_address_control.sv
// address, protocol, setpoint and power sequencing control of the rectifier
`timescale 1ns/100ps
module rectifier_address_control #(
  parameter int unsigned POWERUP_DELAY_CYC = rectifier_pkg::SOFT_DELAY_CYC,
  parameter int unsigned RAMP_CYC = rectifier_pkg::RAMP_CYC,
  parameter int unsigned AUX_LEAD_CYC = rectifier_pkg::AUX_LEAD_CYC,
  parameter int unsigned PG_WARN_CYC = rectifier_pkg::PG_WARN_CYC,
  parameter int unsigned BLINK_HALF_CYC = rectifier_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // configuration pins
  input wire logic protocol_strap_in,
  input wire logic [rectifier_pkg::LEVEL_W-1:0] unit_level_in,
  input wire logic [rectifier_pkg::LEVEL_W-1:0] rack_level_in,
  input wire logic [rectifier_pkg::LEVEL_W-1:0] vprog_level_in,
  // firmware voltage command
  input wire logic fw_vout_stb_in,
  input wire logic [rectifier_pkg::VOUT_W-1:0] fw_vout_value_in,
  // address byte seen on the bus
  input wire logic addr_byte_stb_in,
  input wire logic [7:0] addr_byte_in,
  // power control and sensing
  input wire logic onoff_pin_n_in,
  input wire logic interlock_in,
  input wire logic ac_in_ok_in,
  input wire logic [rectifier_pkg::LEVEL_W-1:0] vin_volts_in,
  // mode and address
  output logic multidrop_mode_out,
  output logic [6:0] bus_address_out,
  output logic address_valid_out,
  output logic addr_match_out,
  output logic broadcast_write_out,
  output logic invalid_command_out,
  // setpoint
  output logic [rectifier_pkg::VOUT_W-1:0] vout_setpoint_out,
  output logic fw_override_out,
  // power sequencing
  output logic main_enable_out,
  output logic ramp_active_out,
  output logic in_regulation_out,
  output logic power_good_warning_out,
  output logic auxiliary_standby_output_out,
  output logic input_led_out
);
  import rectifier_pkg::*;

  // counter limits, cut to counter width once
  localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(POWERUP_DELAY_CYC - 1);
  localparam logic [CNT_W-1:0] AUX_LAST = CNT_W'(AUX_LEAD_CYC - 1);
  localparam logic [CNT_W-1:0] RAMP_LAST = CNT_W'(RAMP_CYC - 1);
  localparam logic [CNT_W-1:0] WARN_LAST = CNT_W'(PG_WARN_CYC - 1);
  localparam logic [CNT_W-1:0] BLINK_LAST = CNT_W'(BLINK_HALF_CYC - 1);

  // linear pin-to-voltage map, about 4.69 output steps per pin step
  function automatic logic [12:0] pin_setpoint(input logic [8:0] lvl);
    logic [15:0] prod;
    prod = 16'(lvl * VPROG_GAIN);
    return VOUT_PIN_BASE + 13'(prod >> VPROG_SHIFT);
  endfunction : pin_setpoint

  logic [3:0] addr_bits;
  logic addr_valid;
  position_decoder u_pos (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .unit_level_in(unit_level_in),
    .rack_level_in(rack_level_in),
    .addr_bits_out(addr_bits),
    .addr_valid_out(addr_valid)
  );

  // strap is caught in the first cycle after reset release
  logic strap_taken_q;
  logic multidrop_q;
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      strap_taken_q <= 1'h0;
      multidrop_q <= 1'h0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'h1;
      multidrop_q <= protocol_strap_in;
    end
  end

  // address byte decode
  wire logic [6:0] own_addr = {ADDR_FIXED, addr_bits};
  wire logic is_bcast = addr_byte_in[7:1] == BCAST_ADDR;
  wire logic is_read = addr_byte_in[0] == DIR_READ;
  wire logic match_d = addr_byte_stb_in && addr_valid && !multidrop_q &&
                       strap_taken_q && addr_byte_in[7:1] == own_addr;
  wire logic bcast_wr_d = addr_byte_stb_in && is_bcast && !is_read;
  wire logic invalid_d = addr_byte_stb_in && is_bcast && is_read;

  // setpoint arbitration: firmware wins from its first command onward
  logic override_q;
  logic [12:0] fw_value_q;
  wire logic override_d = override_q || fw_vout_stb_in;
  wire logic [12:0] fw_value_d = fw_vout_stb_in ? fw_vout_value_in
                                                : fw_value_q;
  wire logic pin_default = vprog_level_in >= VPROG_DEFAULT_MIN;
  wire logic [12:0] pin_value = pin_default ? VOUT_DEFAULT
                                            : pin_setpoint(vprog_level_in);
  wire logic [12:0] vout_d = override_d ? fw_value_d : pin_value;

  // sequencing state
  run_state_t state_q;
  run_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  // interlock always counts; the enable pin only outside multidrop mode
  wire logic run_ok = interlock_in &&
                      (multidrop_q || !onoff_pin_n_in);
  // multidrop still waits the aux lead so the standby rail is up first
  wire logic [CNT_W-1:0] delay_last = multidrop_q ? AUX_LAST
                                                  : DELAY_LAST;
  wire logic cnt_hit_delay = cnt_q == delay_last;
  wire logic cnt_hit_ramp = cnt_q == RAMP_LAST;
  wire logic cnt_hit_warn = cnt_q == WARN_LAST;

  // next state; input loss drops at once, a commanded stop from ramp or on warns first, from delay drops at once
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (strap_taken_q && ac_in_ok_in && run_ok) state_d = ST_DELAY;
      end
      ST_DELAY: begin
        if (!ac_in_ok_in || !run_ok) state_d = ST_OFF;
        else if (cnt_hit_delay) state_d = ST_RAMP;
      end
      ST_RAMP: begin
        if (!ac_in_ok_in) state_d = ST_OFF;
        else if (!run_ok) state_d = ST_WARN;
        else if (cnt_hit_ramp) state_d = ST_ON;
      end
      ST_ON: begin
        if (!ac_in_ok_in) state_d = ST_OFF;
        else if (!run_ok) state_d = ST_WARN;
      end
      ST_WARN: begin
        if (!ac_in_ok_in || cnt_hit_warn) state_d = ST_OFF;
      end
      default: state_d = ST_OFF;
    endcase
  end

  wire logic [CNT_W-1:0] cnt_d = (state_d != state_q) ? '0
                                 : cnt_q + CNT_W'(1);
  wire logic main_d = state_d == ST_RAMP || state_d == ST_ON ||
                      state_d == ST_WARN;
  // warning leads the commanded stop, and rides along any input loss
  wire logic warn_d = state_d == ST_WARN || !ac_in_ok_in;
  wire logic aux_d = strap_taken_q && ac_in_ok_in;

  // input indicator blink timer runs free
  logic [CNT_W-1:0] blink_cnt_q;
  logic blink_phase_q;
  wire logic blink_wrap = blink_cnt_q == BLINK_LAST;
  wire logic led_d = (vin_volts_in >= VIN_LED_MIN) || blink_phase_q;

  // sequencing and blink registers
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_q <= ST_OFF;
      cnt_q <= '0;
      blink_cnt_q <= '0;
      blink_phase_q <= 1'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      blink_cnt_q <= blink_wrap ? '0 : blink_cnt_q + CNT_W'(1);
      blink_phase_q <= blink_phase_q ^ blink_wrap;
    end
  end

  // override only clears through reset, i.e. a bias power restart
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      override_q <= 1'h0;
      fw_value_q <= VOUT_DEFAULT;
    end else begin
      override_q <= override_d;
      fw_value_q <= fw_value_d;
    end
  end

  // output registers
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      multidrop_mode_out <= 1'h0;
      bus_address_out <= {ADDR_FIXED, 4'h0};
      address_valid_out <= 1'h0;
      addr_match_out <= 1'h0;
      broadcast_write_out <= 1'h0;
      invalid_command_out <= 1'h0;
      vout_setpoint_out <= VOUT_DEFAULT;
      fw_override_out <= 1'h0;
      main_enable_out <= 1'h0;
      ramp_active_out <= 1'h0;
      in_regulation_out <= 1'h0;
      power_good_warning_out <= 1'h0;
      auxiliary_standby_output_out <= 1'h0;
      input_led_out <= 1'h0;
    end else begin
      multidrop_mode_out <= multidrop_q;
      bus_address_out <= own_addr;
      address_valid_out <= addr_valid;
      addr_match_out <= match_d;
      broadcast_write_out <= bcast_wr_d;
      invalid_command_out <= invalid_d;
      vout_setpoint_out <= vout_d;
      fw_override_out <= override_d;
      main_enable_out <= main_d;
      ramp_active_out <= state_d == ST_RAMP;
      in_regulation_out <= state_d == ST_ON;
      power_good_warning_out <= warn_d;
      auxiliary_standby_output_out <= aux_d;
      input_led_out <= led_d;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_bcast_read;
    addr_byte_stb_in && addr_byte_in == 8'h01;
  endsequence
  sequence s_stop_cmd;
    (state_q == ST_ON) && ac_in_ok_in && !interlock_in;
  endsequence

  property p_match_upper;
    addr_match_out |-> $past(addr_byte_in[7:5]) == ADDR_FIXED;
  endproperty
  a_match_upper: assert property (p_match_upper)
    else $error("address match outside 40 to 4F");

  property p_bcast_read;
    s_bcast_read |=> invalid_command_out && !broadcast_write_out;
  endproperty
  a_bcast_read: assert property (p_bcast_read)
    else $error("broadcast read not flagged invalid");

  property p_pin_default;
    !fw_override_out && !fw_vout_stb_in &&
      vprog_level_in >= VPROG_DEFAULT_MIN |=> vout_setpoint_out == VOUT_DEFAULT;
  endproperty
  a_pin_default: assert property (p_pin_default)
    else $error("open vprog did not give default setpoint");

  property p_fw_holds;
    fw_override_out && !fw_vout_stb_in |=> $stable(vout_setpoint_out);
  endproperty
  a_fw_holds: assert property (p_fw_holds)
    else $error("setpoint moved with pin after firmware command");

  property p_stop_warns;
    s_stop_cmd |=> power_good_warning_out ##1 main_enable_out;
  endproperty
  a_stop_warns: assert property (p_stop_warns)
    else $error("stop did not warn while output still on");

  property p_multidrop_ignores_pin;
    multidrop_mode_out && state_q == ST_ON && ac_in_ok_in && interlock_in
      |=> main_enable_out;
  endproperty
  a_multidrop_ignores_pin: assert property (p_multidrop_ignores_pin)
    else $error("enable pin acted in multidrop mode");

  property p_aux_leads;
    $rose(main_enable_out) |-> $past(auxiliary_standby_output_out, 8);
  endproperty
  a_aux_leads: assert property (p_aux_leads)
    else $error("main output rose before auxiliary output");

  // sampled reset keeps the release edge, where the LED is still low, out
  property p_led_steady;
    rstn_in && vin_volts_in >= VIN_LED_MIN |=> input_led_out;
  endproperty
  a_led_steady: assert property (p_led_steady)
    else $error("input LED not steady at good input");

  property p_ramp_from_delay;
    $rose(ramp_active_out) |-> $past(state_q) == ST_DELAY;
  endproperty
  a_ramp_from_delay: assert property (p_ramp_from_delay)
    else $error("ramp started without the start delay");
endmodule : rectifier_address_control

// file: test/host_model.sv
// host side model: sends address bytes and voltage commands
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic clk_in,
  // address byte and firmware command towards the block
  output logic addr_byte_stb_out,
  output logic [7:0] addr_byte_out,
  output logic fw_vout_stb_out,
  output logic [rectifier_pkg::VOUT_W-1:0] fw_vout_value_out
);
  import rectifier_pkg::*;

  // idle bus at time zero
  initial begin
    addr_byte_stb_out = 1'b0;
    addr_byte_out = 8'h00;
    fw_vout_stb_out = 1'b0;
    fw_vout_value_out = '0;
  end

  // one byte per call; the released byte is inverted so no stale match
  task automatic send_addr(input logic [6:0] a, input logic rd);
    @(posedge clk_in);
    addr_byte_stb_out <= 1'b1;
    addr_byte_out <= {a, rd};
    @(posedge clk_in);
    addr_byte_stb_out <= 1'b0;
    addr_byte_out <= ~{a, rd};
  endtask : send_addr

  // executed output voltage command
  task automatic send_vout(input logic [VOUT_W-1:0] v);
    @(posedge clk_in);
    fw_vout_stb_out <= 1'b1;
    fw_vout_value_out <= v;
    @(posedge clk_in);
    fw_vout_stb_out <= 1'b0;
    fw_vout_value_out <= ~v;
  endtask : send_vout
endmodule : host_model

// file: test/rectifier_address_control_tb.sv
// self-checking bench of the rectifier address and control block
`timescale 1ns/100ps
module rectifier_address_control_tb;
  import rectifier_pkg::*;
  // shortened counts keep the run brief
  localparam int DELAY_T = 40;
  localparam int RAMP_T = 20;
  localparam int LEAD_T = 16;
  localparam int WARN_T = 5;
  localparam int BLINK_T = 6;
  localparam logic [8:0] UNIT_LV [10] = '{9'h12c, 9'h10b, 9'h0ea, 9'h0c9,
    9'h0a8, 9'h087, 9'h066, 9'h045, 9'h024, 9'h000};
  localparam logic [8:0] RACK_LV [8] = '{9'h14a, 9'h118, 9'h0e6, 9'h0b4,
    9'h08c, 9'h064, 9'h032, 9'h000};
  logic clk_in, rstn_in, protocol_strap_in, onoff_pin_n_in, interlock_in;
  logic ac_in_ok_in, fw_vout_stb_in, addr_byte_stb_in;
  logic [8:0] unit_level_in, rack_level_in, vprog_level_in, vin_volts_in;
  logic [12:0] fw_vout_value_in, vout_setpoint_out;
  logic [7:0] addr_byte_in;
  logic [6:0] bus_address_out;
  logic multidrop_mode_out, address_valid_out, addr_match_out;
  logic broadcast_write_out, invalid_command_out, fw_override_out;
  logic main_enable_out, ramp_active_out, in_regulation_out;
  logic power_good_warning_out, auxiliary_standby_output_out, input_led_out;
  int err_count = 0;
  int cmp_count = 0;

  rectifier_address_control #(.POWERUP_DELAY_CYC(DELAY_T),
    .RAMP_CYC(RAMP_T), .AUX_LEAD_CYC(LEAD_T), .PG_WARN_CYC(WARN_T),
    .BLINK_HALF_CYC(BLINK_T)) i_dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .protocol_strap_in(protocol_strap_in), .unit_level_in(unit_level_in),
    .rack_level_in(rack_level_in), .vprog_level_in(vprog_level_in),
    .fw_vout_stb_in(fw_vout_stb_in), .fw_vout_value_in(fw_vout_value_in),
    .addr_byte_stb_in(addr_byte_stb_in), .addr_byte_in(addr_byte_in),
    .onoff_pin_n_in(onoff_pin_n_in), .interlock_in(interlock_in),
    .ac_in_ok_in(ac_in_ok_in), .vin_volts_in(vin_volts_in),
    .multidrop_mode_out(multidrop_mode_out),
    .bus_address_out(bus_address_out),
    .address_valid_out(address_valid_out), .addr_match_out(addr_match_out),
    .broadcast_write_out(broadcast_write_out),
    .invalid_command_out(invalid_command_out),
    .vout_setpoint_out(vout_setpoint_out), .fw_override_out(fw_override_out),
    .main_enable_out(main_enable_out), .ramp_active_out(ramp_active_out),
    .in_regulation_out(in_regulation_out),
    .power_good_warning_out(power_good_warning_out),
    .auxiliary_standby_output_out(auxiliary_standby_output_out),
    .input_led_out(input_led_out));

  host_model i_host (.clk_in(clk_in), .addr_byte_stb_out(addr_byte_stb_in),
    .addr_byte_out(addr_byte_in), .fw_vout_stb_out(fw_vout_stb_in),
    .fw_vout_value_out(fw_vout_value_in));

  // free running clock
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // expected address nibble with valid flag on top
  function automatic logic [4:0] addr_of(input int u, input int r);
    if (u <= 4 && r <= 4) return {1'b1, 4'((r - 1) * 4 + u - 1)};
    if (u <= 5 && r >= 6) return {1'b1, 4'((r - 6) * 5 + u - 1)};
    if (u == 6 || u == 7) return {1'b1, 4'((r - 1) * 2 + u - 6)};
    if (u >= 8 && r >= 4) return {1'b1, 4'((r - 4) * 3 + u - 8)};
    return 5'h00;
  endfunction : addr_of

  function automatic logic [12:0] pin_v(input logic [8:0] l);
    return VOUT_PIN_BASE + 13'((int'(l) * int'(VPROG_GAIN)) >> VPROG_SHIFT);
  endfunction : pin_v

  // reset stands in for a bias restart; strap is taken after release
  task automatic do_reset(input logic s);
    @(posedge clk_in);
    rstn_in <= 1'b0;
    protocol_strap_in <= s;
    repeat (12) @(posedge clk_in);
    #1;
    check("rst addr", bus_address_out, 7'h40);
    check("rst vout", vout_setpoint_out, VOUT_DEFAULT);
    check("rst main", {main_enable_out, auxiliary_standby_output_out}, 0);
    @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : do_reset

  task automatic test_address;
    logic [4:0] e;
    check("mode", multidrop_mode_out, 1'b0);
    for (int u = 1; u <= 10; u++) begin
      for (int r = 1; r <= 8; r++) begin
        @(posedge clk_in);
        unit_level_in <= UNIT_LV[u-1];
        rack_level_in <= RACK_LV[r-1];
        e = addr_of(u, r);
        repeat (4) @(posedge clk_in);
        #1;
        check("valid", address_valid_out, e[4]);
        if (e[4]) begin
          check("addr", bus_address_out, {ADDR_FIXED, e[3:0]});
          // match pulse stands only in the cycle after the strobe edge
          i_host.send_addr({ADDR_FIXED, e[3:0]}, u[0]);
          #1;
          check("match", addr_match_out, 1'b1);
          i_host.send_addr({ADDR_FIXED, ~e[3:0]}, 1'b0);
          #1;
          check("other", addr_match_out, 1'b0);
        end
      end
    end
    i_host.send_addr(BCAST_ADDR, 1'b0);
    #1;
    check("bcast", {broadcast_write_out, invalid_command_out}, 2'h2);
    i_host.send_addr(BCAST_ADDR, DIR_READ);
    #1;
    check("bread", invalid_command_out, 1'b1);
    $display("test address done");
  endtask : test_address

  task automatic set_vprog(input logic [8:0] l);
    @(posedge clk_in);
    vprog_level_in <= l;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : set_vprog

  task automatic test_vprog;
    set_vprog(VPROG_DEFAULT_MIN);
    check("default", vout_setpoint_out, VOUT_DEFAULT);
    set_vprog(9'h12b);
    check("pin", vout_setpoint_out, pin_v(9'h12b));
    i_host.send_vout(13'h1388);
    @(posedge clk_in);
    #1;
    check("fw", {fw_override_out, vout_setpoint_out}, 14'h3388);
    set_vprog(9'h064);
    check("ignored", vout_setpoint_out, 13'h1388);
    do_reset(1'b0);
    check("restart", vout_setpoint_out, pin_v(9'h064));
    check("no ovr", fw_override_out, 1'b0);
    $display("test vprog done");
  endtask : test_vprog

  // full power up, then commanded off; md selects multidrop handling
  task automatic test_power(input logic md);
    int n, a, m, g, w, d;
    d = md ? LEAD_T : DELAY_T;
    @(posedge clk_in);
    ac_in_ok_in <= 1'b0;
    interlock_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    ac_in_ok_in <= 1'b1;
    interlock_in <= 1'b1;
    onoff_pin_n_in <= md;
    n = 0;
    a = -1;
    m = -1;
    g = -1;
    while (g < 0 && n < 400) begin
      @(posedge clk_in);
      #1;
      n++;
      if (a < 0 && auxiliary_standby_output_out === 1'b1) a = n;
      if (m < 0 && main_enable_out === 1'b1) begin
        m = n;
        check("ramp on", ramp_active_out, 1'b1);
      end
      if (g < 0 && in_regulation_out === 1'b1) g = n;
    end
    check("aux", a > 0 && a <= 3, 1'b1);
    check("start", m >= d && m <= d + 4, 1'b1);
    check("ramp", g - m >= RAMP_T && g - m <= RAMP_T + 1, 1'b1);
    check("ramp end", ramp_active_out, 1'b0);
    check("lead", g - a >= LEAD_T, 1'b1);
    @(posedge clk_in);
    if (md) interlock_in <= 1'b0;
    else onoff_pin_n_in <= 1'b1;
    w = 0;
    repeat (30) begin
      @(posedge clk_in);
      #1;
      if (main_enable_out === 1'b1 && power_good_warning_out === 1'b1) w++;
    end
    check("warn", w >= WARN_T - 1 && w <= WARN_T + 1, 1'b1);
    check("off", main_enable_out, 1'b0);
    $display("test power done");
  endtask : test_power

  task automatic toggles(output int t);
    logic p;
    t = 0;
    p = input_led_out;
    repeat (4 * BLINK_T) begin
      @(posedge clk_in);
      #1;
      if (input_led_out !== p) t++;
      p = input_led_out;
    end
  endtask : toggles

  task automatic test_led;
    int t;
    @(posedge clk_in);
    vin_volts_in <= VIN_LED_MIN;
    repeat (3) @(posedge clk_in);
    #1;
    check("lit", input_led_out, 1'b1);
    toggles(t);
    check("steady", t, 0);
    @(posedge clk_in);
    vin_volts_in <= VIN_LED_MIN - 9'h001;
    toggles(t);
    check("blink", t >= 3 && t <= 5, 1'b1);
    $display("test led done");
  endtask : test_led

  task automatic test_multidrop;
    do_reset(1'b1);
    check("md mode", multidrop_mode_out, 1'b1);
    i_host.send_addr(bus_address_out, 1'b0);
    #1;
    check("md match", addr_match_out, 1'b0);
    test_power(1'b1);
    $display("test multidrop done");
  endtask : test_multidrop

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    $display("watchdog expired");
    complete_run();
  end

  // main sequence
  initial begin
    rstn_in = 1'b0;
    protocol_strap_in = 1'b0;
    unit_level_in = 9'h12c;
    rack_level_in = 9'h14a;
    vprog_level_in = 9'h12c;
    onoff_pin_n_in = 1'b1;
    interlock_in = 1'b0;
    ac_in_ok_in = 1'b0;
    vin_volts_in = 9'h0e6;
    do_reset(1'b0);
    test_address();
    test_vprog();
    test_power(1'b0);
    test_led();
    test_multidrop();
    complete_run();
  end
endmodule : rectifier_address_control_tb
